// ### include/dbg_bkpt_pkg.sv
// package: constants and carrier types for the debug breakpoint and force-reset block
package dbg_bkpt_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // breakpoint register reset value
  localparam logic [15:0] BKPT_RESET = 16'h0000;
  // force-reset register: read value and field position
  localparam logic [7:0] FORCE_RESET_READ = 8'h00;
  localparam int FORCE_RESET_BIT_POS = 0;
  // debug status/control field positions used here
  localparam int BKPT_EN_POS = 5;
  localparam int FTS_POS = 4;
  // length of the reset request pulse in cycles
  localparam int RESET_PULSE_CYCLES = 1;

  // serial debug command kinds seen by this block
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_READ_BREAKPOINT_CMD,
    CMD_WRITE_BREAKPOINT_CMD,
    CMD_WRITE_FORCE_RESET
  } dbg_cmd_t;

  // one decoded debug command
  typedef struct packed {
    logic valid;
    dbg_cmd_t cmd;
    logic [15:0] wdata;
  } dbg_req_t;

  // cpu bus view for the comparator
  typedef struct packed {
    logic fetch;
    logic [15:0] addr;
  } cpu_bus_t;

  // user program bus write attempt
  typedef struct packed {
    logic wr;
    logic [7:0] wdata;
  } user_wr_t;

endpackage

// ### design/bkpt_compare.sv
// address comparator with force/tag decision
`timescale 1ns/10ps
module bkpt_compare (
  // configuration
  input wire logic i_enable,
  input wire logic i_force_sel,
  input wire logic [15:0] i_bkpt_addr,
  // cpu bus
  input wire dbg_bkpt_pkg::cpu_bus_t i_bus,
  // results
  output logic o_force_hit,
  output logic o_tag_hit
);
  import dbg_bkpt_pkg::*;

  logic match;

  assign match = i_enable && (i_bus.addr == i_bkpt_addr);
  assign o_force_hit = match && i_force_sel;
  assign o_tag_hit = match && !i_force_sel && i_bus.fetch;
endmodule

// ### design/dbg_bkpt_force_reset.sv
// breakpoint match register, force-reset register and breakpoint request logic
`timescale 1ns/10ps
// Behaviour
// - a 16-bit breakpoint address register feeds the breakpoint comparator
// - enable and force/tag mode come from status/control bits, not this register
// - breakpoint register reached only by serial read/write breakpoint commands
// - force-reset register has one write-only control bit
// - user program writes ignored; host writes via serial memory-write command
// - force-reset register always reads zero
// - host writing one to bit 0 asserts a full system reset
// - enable bit clear disables breakpoint, ignoring mode and address; a tagged opcode reaching queue end still enters background
// - force mode: match forces background mode at next instruction boundary
// - tag mode: match tags opcode, background entered only if it reaches queue end
module dbg_bkpt_force_reset (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // serial debug command port
  input wire dbg_bkpt_pkg::dbg_req_t i_dbg_req,
  output logic [15:0] o_dbg_rdata,
  output logic o_dbg_rvalid,
  // user program write attempt to force-reset register
  input wire dbg_bkpt_pkg::user_wr_t i_user_wr,
  // debug status/control bits
  input wire logic [7:0] i_debug_status_control,
  // cpu pipeline
  input wire dbg_bkpt_pkg::cpu_bus_t i_cpu_bus,
  input wire logic i_insn_boundary,
  input wire logic i_queue_end,
  input wire logic i_queue_end_tagged,
  // outputs
  output logic o_tag_opcode,
  output logic o_enter_background,
  output logic o_force_system_reset
);
  import dbg_bkpt_pkg::*;

  logic [15:0] bkpt_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic reset_pulse_q;
  logic reset_pulse_d;
  logic enter_q;
  logic enter_d;
  logic force_hit;
  logic tag_hit;
  logic bkpt_en;
  logic force_or_tag_select;
  logic cmd_rd_bkpt;
  logic cmd_wr_bkpt;
  logic cmd_wr_force;
  logic force_bit;
  logic force_req;
  logic force_exec;
  logic tag_exec;
  logic unused_user;

  // force-mode breakpoint progress
  typedef enum logic [1:0] {
    BP_OFF,
    BP_WATCH,
    BP_PENDING
  } bp_state_t;

  bp_state_t bp_state_q;
  bp_state_t bp_state_d;

  // control bits from the status/control register
  assign bkpt_en = i_debug_status_control[BKPT_EN_POS];
  assign force_or_tag_select = i_debug_status_control[FTS_POS];

  // command decode, one strobe per command kind except CMD_NONE, all held low while the clock enable is low
  always_comb begin
    cmd_rd_bkpt = 1'b0;
    cmd_wr_bkpt = 1'b0;
    cmd_wr_force = 1'b0;
    if (!i_clk_en || !i_dbg_req.valid) begin
      cmd_rd_bkpt = 1'b0;
    end else if (i_dbg_req.cmd == CMD_READ_BREAKPOINT_CMD) begin
      cmd_rd_bkpt = 1'b1;
    end else if (i_dbg_req.cmd == CMD_WRITE_BREAKPOINT_CMD) begin
      cmd_wr_bkpt = 1'b1;
    end else if (i_dbg_req.cmd == CMD_WRITE_FORCE_RESET) begin
      cmd_wr_force = 1'b1;
    end
  end

  // only one bit of the force-reset register is implemented
  assign force_bit = i_dbg_req.wdata[FORCE_RESET_BIT_POS];
  assign force_req = cmd_wr_force && force_bit;

  // breakpoint register, written only by serial command
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bkpt_q <= BKPT_RESET;
    end else if (cmd_wr_bkpt) begin
      bkpt_q <= i_dbg_req.wdata;
    end
  end

  // one answer strobe for each serial read or force-reset access
  assign rvalid_d = cmd_rd_bkpt || cmd_wr_force;

  // read answer strobe
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
    end else if (i_clk_en) begin
      rvalid_q <= rvalid_d;
    end
  end

  // read data source, held until the next answer
  always_comb begin
    rdata_d = rdata_q;
    if (cmd_rd_bkpt) begin
      rdata_d = bkpt_q;
    end else if (cmd_wr_force) begin
      rdata_d = {8'h00, FORCE_RESET_READ};
    end
  end

  // read data register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 16'h0000;
    end else if (i_clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // force-reset request is a pulse, the bit itself is never stored
  assign reset_pulse_d = force_req;

  // force-reset pulse register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reset_pulse_q <= 1'b0;
    end else if (i_clk_en) begin
      reset_pulse_q <= reset_pulse_d;
    end
  end

  // user program writes have no path into the block
  assign unused_user = i_user_wr.wr ^ (|i_user_wr.wdata);

  bkpt_compare u_cmp (
    .i_enable(bkpt_en),
    .i_force_sel(force_or_tag_select),
    .i_bkpt_addr(bkpt_q),
    .i_bus(i_cpu_bus),
    .o_force_hit(force_hit),
    .o_tag_hit(tag_hit)
  );

  // force match held until the next instruction boundary; a new match wins
  always_comb begin
    bp_state_d = bp_state_q;
    case (bp_state_q)
      BP_OFF: begin
        if (force_hit) begin
          bp_state_d = BP_PENDING;
        end else if (bkpt_en) begin
          bp_state_d = BP_WATCH;
        end
      end
      BP_WATCH: begin
        if (!bkpt_en) begin
          bp_state_d = BP_OFF;
        end else if (force_hit) begin
          bp_state_d = BP_PENDING;
        end
      end
      BP_PENDING: begin
        if (!bkpt_en) begin
          bp_state_d = BP_OFF;
        end else if (force_hit) begin
          bp_state_d = BP_PENDING;
        end else if (i_insn_boundary) begin
          bp_state_d = BP_WATCH;
        end
      end
      default: begin
        bp_state_d = BP_OFF;
      end
    endcase
  end

  // force-mode state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bp_state_q <= BP_OFF;
    end else if (i_clk_en) begin
      bp_state_q <= bp_state_d;
    end
  end

  // entry causes: pending force match at a boundary, or tagged opcode at queue end
  assign force_exec = (bp_state_q == BP_PENDING) && i_insn_boundary;
  assign tag_exec = i_queue_end && i_queue_end_tagged;
  assign enter_d = force_exec || tag_exec;

  // background entry request
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enter_q <= 1'b0;
    end else if (i_clk_en) begin
      enter_q <= enter_d;
    end
  end

  // outputs
  assign o_tag_opcode = tag_hit;
  assign o_enter_background = enter_q;
  assign o_force_system_reset = reset_pulse_q;
  assign o_dbg_rdata = rdata_q;
  assign o_dbg_rvalid = rvalid_q;
endmodule

// ### tb/dbg_host.sv
// debug host model that issues serial-decoded commands
`timescale 1ns/10ps
module dbg_host (
  // clock
  input wire logic i_sys_clk,
  // command out
  output dbg_bkpt_pkg::dbg_req_t o_req
);
  import dbg_bkpt_pkg::*;
  initial o_req = '0;
  // one-cycle pulse; released data is inverted so it cannot be mistaken for held
  task send(input dbg_cmd_t c, input logic [15:0] d);
    @(posedge i_sys_clk) #1 o_req = {1'b1, c, d};
    @(posedge i_sys_clk) #1 o_req = {1'b0, CMD_NONE, ~d};
  endtask
endmodule

// ### tb/dbg_chk.sv
// port assertions for the breakpoint and force-reset block
`timescale 1ns/10ps
module dbg_chk (
  // watched ports
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire dbg_bkpt_pkg::dbg_req_t i_dbg_req,
  input wire logic [15:0] o_dbg_rdata,
  input wire logic o_dbg_rvalid,
  input wire logic [7:0] i_debug_status_control,
  input wire logic i_queue_end,
  input wire logic i_queue_end_tagged,
  input wire logic o_tag_opcode,
  input wire logic o_enter_background,
  input wire logic o_force_system_reset
);
  import dbg_bkpt_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  wire f = i_clk_en && i_dbg_req.valid && i_dbg_req.cmd == CMD_WRITE_FORCE_RESET;
  wire [1:0] m = i_debug_status_control[5:4];
  wire q = i_clk_en && i_queue_end && i_queue_end_tagged;
  rst_req_a: assert property (f && i_dbg_req.wdata[0] |=> o_force_system_reset)
    else $error("no reset");
  rst_one_a: assert property (o_force_system_reset && i_clk_en && !(f && i_dbg_req.wdata[0])
    |=> !o_force_system_reset)
    else $error("long reset");
  rst_src_a: assert property ($rose(o_force_system_reset) |-> $past(f && i_dbg_req.wdata[0]))
    else $error("stray reset");
  zero_read_a: assert property (f |=> o_dbg_rvalid && o_dbg_rdata == 16'h0000)
    else $error("nonzero read");
  bk_read_a: assert property (i_clk_en && i_dbg_req.valid && i_dbg_req.cmd == CMD_READ_BREAKPOINT_CMD
    |=> o_dbg_rvalid)
    else $error("no answer");
  tag_mode_a: assert property (o_tag_opcode |-> m == 2'b10)
    else $error("bad tag");
  bp_off_a: assert property (i_clk_en && $past(i_clk_en) && !m[1] && $past(!m[1]) && !q
    |=> !o_enter_background)
    else $error("break while off");
  tag_go_a: assert property (q |=> o_enter_background)
    else $error("no entry");
endmodule
bind dbg_bkpt_force_reset dbg_chk chk (.*);

// ### tb/dbg_bkpt_force_reset_bench.sv
// self-checking bench for the breakpoint and force-reset block
`timescale 1ns/10ps
module dbg_bkpt_force_reset_bench;
  import dbg_bkpt_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, ib = 0, qe = 0, qt = 0, rv, tg, eb, fr;
  logic [7:0] sc = 0;
  logic [15:0] rd, bk = BKPT_RESET;
  cpu_bus_t cb = '0;
  user_wr_t uw = '0;
  dbg_req_t rq;
  int failures = 0, checks = 0;
  always #20 clk = ~clk;
  dbg_host h (.i_sys_clk(clk), .o_req(rq));
  dbg_bkpt_force_reset dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce),
    .i_dbg_req(rq), .o_dbg_rdata(rd), .o_dbg_rvalid(rv), .i_user_wr(uw),
    .i_debug_status_control(sc), .i_cpu_bus(cb), .i_insn_boundary(ib), .i_queue_end(qe),
    .i_queue_end_tagged(qt), .o_tag_opcode(tg), .o_enter_background(eb),
    .o_force_system_reset(fr));
  task ck(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error %0t mismatch", $time);
    end
  endtask
  task tk;
    @(posedge clk) #1;
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3ef29e7e));
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    h.send(CMD_READ_BREAKPOINT_CMD, 16'h0);
    ck(rv === 1'b1 && rd === bk);
    repeat (4) begin
      bk = 16'($urandom);
      h.send(CMD_WRITE_BREAKPOINT_CMD, bk);
      h.send(CMD_READ_BREAKPOINT_CMD, ~bk);
      ck(rv === 1'b1 && rd === bk);
    end
    ce = 0;
    h.send(CMD_WRITE_FORCE_RESET, 16'h0001);
    ck(fr === 1'b0);
    h.send(CMD_WRITE_BREAKPOINT_CMD, ~bk);
    ce = 1;
    h.send(CMD_READ_BREAKPOINT_CMD, 16'h0);
    ck(rv === 1'b1 && rd === bk);
    uw = {1'b1, 8'($urandom) | 8'h01};
    tk;
    uw = '0;
    ck(fr === 1'b0);
    h.send(CMD_WRITE_FORCE_RESET, 16'h0001);
    ck(fr === 1'b1 && rv === 1'b1 && rd === 16'h0000);
    tk;
    ck(fr === 1'b0);
    h.send(CMD_WRITE_FORCE_RESET, 16'hfffe);
    ck(fr === 1'b0 && rv === 1'b1 && rd === 16'h0000);
    rst_n = 0;
    tk;
    tk;
    rst_n = 1;
    h.send(CMD_READ_BREAKPOINT_CMD, 16'h0);
    ck(rv === 1'b1 && rd === BKPT_RESET);
    bk = 16'($urandom);
    h.send(CMD_WRITE_BREAKPOINT_CMD, bk);
    sc = 8'h30;
    cb = {1'b1, bk};
    tk;
    cb = {1'b0, ~bk};
    ib = 1;
    tk;
    ib = 0;
    ck(eb === 1'b1);
    sc = 8'h20;
    cb = {1'b1, bk};
    tk;
    ck(tg === 1'b1);
    cb.addr = ~bk;
    tk;
    ck(tg === 1'b0);
    qe = 1;
    qt = 1;
    tk;
    qe = 0;
    qt = 0;
    ck(eb === 1'b1);
    sc = 8'($urandom) & 8'hcf;
    cb = {1'b1, bk};
    tk;
    ck(tg === 1'b0);
    sc = sc | 8'h10;
    ib = 1;
    tk;
    tk;
    ck(eb === 1'b0);
    print_verdict;
  end
endmodule
